// *** logic/cfg_decoder_cfg.svh ***
`ifndef CFG_DECODER_CFG_SVH
`define CFG_DECODER_CFG_SVH

// Register byte addresses.
`define REG_CTRL 8'h00
`define REG_BYTE 8'h04
`define REG_STATUS 8'h08
`define REG_IFACE 8'h0c
`define REG_FEAT 8'h10
`define REG_PSEL 8'h14
`define REG_PDATA 8'h18

// Control register bits.
`define CTRL_START_BIT 0
`define CTRL_FORGET_BIT 1

// Entry index byte fields.
`define IDX_IFACE_BIT 7
`define IDX_DEFAULT_BIT 6
`define IDX_NUM_MSB 5

// Interface description byte fields.
`define IF_TYPE_MSB 3
`define IF_BATT_BIT 4
`define IF_WP_BIT 5
`define IF_READY_BIT 6
`define IF_MWAIT_BIT 7
`define IF_DEFAULT_VAL 8'h70
`define IF_TYPE_MEM 4'h0
`define IF_TYPE_IOMEM 4'h1
`define IF_TYPE_CUST_LO 4'h4
`define IF_TYPE_CUST_HI 4'h7

// Feature select byte fields.
`define FS_PWR_MSB 1
`define FS_PWR_LSB 0
`define FS_TIMING_BIT 2
`define FS_IO_BIT 3
`define FS_IRQ_BIT 4
`define FS_MEM_MSB 6
`define FS_MEM_LSB 5
`define FS_MISC_BIT 7

// Power structure bytes.
`define SEL_RSV_BIT 7
`define MORE_BIT 7
`define MANT_MSB 6
`define MANT_LSB 3
`define EXPO_MSB 2
`define NUM_VOLT_PARAMS 3
`define DIGITS_MAX 8'h63
`define XC_RSV_HI 8'h7c
`define XC_NC_SLEEP 8'h7d
`define XC_ZERO 8'h7e
`define XC_NC_REQ 8'h7f

// Error bits in the status register.
`define ERR_TYPE 0
`define ERR_SEL 1
`define ERR_XRSV 2
`define ERR_XPOS 3

// Timing.
`define CLK_PERIOD_NS 40
`define WAIT_MAX_US 12
`define WAIT_MAX_CYC ((`WAIT_MAX_US * 1000) / `CLK_PERIOD_NS)

`endif

// *** logic/cfg_decoder_pkg.sv ***
package cfg_decoder_pkg;

    typedef enum logic [6:0] {
        ST_INDEX = 7'b0000001,
        ST_IFACE = 7'b0000010,
        ST_FSEL = 7'b0000100,
        ST_PSEL = 7'b0001000,
        ST_PFIRST = 7'b0010000,
        ST_PMORE = 7'b0100000,
        ST_DONE = 7'b1000000
    } scan_state_t;

    typedef enum logic [1:0] {
        SPC_NONE = 2'b00,
        SPC_NC_SLEEP = 2'b01,
        SPC_ZERO = 2'b10,
        SPC_NC_REQ = 2'b11
    } special_t;

    typedef struct packed {
        logic valid;
        logic [3:0] mant;
        logic [2:0] expo;
        logic [6:0] digits;
        logic [2:0] count;
        special_t special;
    } param_entry_t;

endpackage

// *** logic/config_entry_field_decoder.sv ***
`include "cfg_decoder_cfg.svh"

module config_entry_field_decoder
    import cfg_decoder_pkg::*;
#(
    parameter int NUM_STRUCTS = 3,
    parameter int NUM_PARAMS = 7
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o
);

    localparam int DEPTH = NUM_STRUCTS * NUM_PARAMS;
    localparam int IW = $clog2(DEPTH);

    scan_state_t state_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic dflt_q;
    logic [5:0] entry_no_q;
    logic [7:0] if_q;
    logic if_given_q;
    logic [7:0] fs_q;
    logic have_def_q;
    logic [7:0] def_if_q;
    logic [7:0] def_fs_q;
    logic [3:0] err_q;
    logic [1:0] ps_q;
    logic [6:0] pmask_q;
    logic [2:0] pidx_q;
    param_entry_t cur_q;
    logic [IW-1:0] psel_q;
    param_entry_t cur_bank [DEPTH];
    param_entry_t def_bank [DEPTH];
    logic [DEPTH-1:0] cur_vld_q;
    logic [DEPTH-1:0] def_vld_q;

    logic wb_req;
    logic wr;
    logic byte_v;
    logic [7:0] b;
    logic start;
    logic forget;
    logic [3:0] err_set;
    param_entry_t par_d;
    logic par_done;
    logic [2:0] low_idx;
    logic [6:0] mask_left;
    logic [IW-1:0] wr_idx;

    function automatic logic [2:0] lowest(input logic [6:0] m);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 6; i >= 0; i--) begin
            if (m[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // Mantissa in tenths.
    function automatic logic [6:0] mant_tenths(input logic [3:0] c);
        case (c)
            4'h0: return 7'h0a;
            4'h1: return 7'h0c;
            4'h2: return 7'h0d;
            4'h3: return 7'h0f;
            4'h4: return 7'h14;
            4'h5: return 7'h19;
            4'h6: return 7'h1e;
            4'h7: return 7'h23;
            4'h8: return 7'h28;
            4'h9: return 7'h2d;
            4'ha: return 7'h32;
            4'hb: return 7'h37;
            4'hc: return 7'h3c;
            4'hd: return 7'h46;
            4'he: return 7'h50;
            default: return 7'h5a;
        endcase
    endfunction

    function automatic logic type_reserved(input logic [3:0] t);
        return !(t == `IF_TYPE_MEM || t == `IF_TYPE_IOMEM ||
                 (t >= `IF_TYPE_CUST_LO && t <= `IF_TYPE_CUST_HI));
    endfunction

    assign wb_req = cyc_i & stb_i & ~ack_q;
    assign wr = wb_req & we_i & sel_i[0];
    assign byte_v = wr & (adr_i == `REG_BYTE);
    assign b = dat_i[7:0];
    assign start = wr & (adr_i == `REG_CTRL) & dat_i[`CTRL_START_BIT];
    assign forget = wr & (adr_i == `REG_CTRL) & dat_i[`CTRL_FORGET_BIT];
    assign ack_o = ack_q;
    assign dat_o = dat_q;
    assign low_idx = lowest(pmask_q);
    assign mask_left = pmask_q & ~(7'h01 << low_idx);

    // Effective view: own field if present, else the default entry's, else none.
    logic inherit;
    logic [1:0] eff_pwr;
    logic pwr_from_def;
    logic eff_timing;
    logic eff_io;
    logic eff_irq;
    logic [1:0] eff_mem;
    logic eff_misc;
    assign inherit = have_def_q & ~dflt_q;
    assign pwr_from_def = (fs_q[`FS_PWR_MSB:`FS_PWR_LSB] == 2'h0) & inherit;
    assign eff_pwr = pwr_from_def ? def_fs_q[`FS_PWR_MSB:`FS_PWR_LSB]
                                  : fs_q[`FS_PWR_MSB:`FS_PWR_LSB];
    assign eff_timing = fs_q[`FS_TIMING_BIT] | (inherit & def_fs_q[`FS_TIMING_BIT]);
    assign eff_io = fs_q[`FS_IO_BIT] | (inherit & def_fs_q[`FS_IO_BIT]);
    assign eff_irq = fs_q[`FS_IRQ_BIT] | (inherit & def_fs_q[`FS_IRQ_BIT]);
    assign eff_misc = fs_q[`FS_MISC_BIT] | (inherit & def_fs_q[`FS_MISC_BIT]);
    assign eff_mem = (fs_q[`FS_MEM_MSB:`FS_MEM_LSB] == 2'h0 && inherit)
                   ? def_fs_q[`FS_MEM_MSB:`FS_MEM_LSB]
                   : fs_q[`FS_MEM_MSB:`FS_MEM_LSB];

    // Parameter being built and its error checks.
    always_comb begin
        par_d = cur_q;
        par_done = 1'b0;
        err_set = 4'h0;
        if (byte_v) begin
            case (state_q)
                ST_IFACE: begin
                    err_set[`ERR_TYPE] = type_reserved(b[`IF_TYPE_MSB:0]);
                end
                ST_PSEL: begin
                    err_set[`ERR_SEL] = b[`SEL_RSV_BIT];
                end
                ST_PFIRST: begin
                    par_d.valid = 1'b1;
                    par_d.mant = b[`MANT_MSB:`MANT_LSB];
                    par_d.expo = b[`EXPO_MSB:0];
                    par_d.digits = 7'h00;
                    par_d.count = 3'h0;
                    par_d.special = SPC_NONE;
                    par_done = ~b[`MORE_BIT];
                end
                ST_PMORE: begin
                    par_done = ~b[`MORE_BIT];
                    if (cur_q.count != 3'h7) begin
                        par_d.count = cur_q.count + 3'h1;
                    end
                    if (b[6:0] <= `DIGITS_MAX) begin
                        if (cur_q.count == 3'h0) begin
                            par_d.digits = b[6:0];
                        end
                    end else if (b[6:0] <= `XC_RSV_HI) begin
                        err_set[`ERR_XRSV] = 1'b1;
                    end else if (b[6:0] == `XC_NC_SLEEP) begin
                        par_d.special = SPC_NC_SLEEP;
                        err_set[`ERR_XPOS] = b[`MORE_BIT];
                    end else begin
                        par_d.special = (b[6:0] == `XC_ZERO) ? SPC_ZERO : SPC_NC_REQ;
                        err_set[`ERR_XPOS] = b[`MORE_BIT] | (cur_q.count != 3'h0);
                    end
                end
                default: begin
                    par_done = 1'b0;
                end
            endcase
        end
    end

    // Scan sequencer, one byte per accepted write to the byte register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_INDEX;
            dflt_q <= 1'b0;
            entry_no_q <= 6'h00;
            if_q <= `IF_DEFAULT_VAL;
            if_given_q <= 1'b0;
            fs_q <= 8'h00;
            ps_q <= 2'h0;
            pmask_q <= 7'h00;
            pidx_q <= 3'h0;
            cur_q <= '0;
        end else if (start) begin
            state_q <= ST_INDEX;
        end else if (byte_v) begin
            cur_q <= par_d;
            case (state_q)
                ST_INDEX: begin
                    dflt_q <= b[`IDX_DEFAULT_BIT];
                    entry_no_q <= b[`IDX_NUM_MSB:0];
                    if_given_q <= b[`IDX_IFACE_BIT];
                    fs_q <= 8'h00;
                    if (b[`IDX_IFACE_BIT]) begin
                        state_q <= ST_IFACE;
                    end else begin
                        if_q <= (have_def_q & ~b[`IDX_DEFAULT_BIT]) ? def_if_q
                                                                     : `IF_DEFAULT_VAL;
                        state_q <= ST_FSEL;
                    end
                end
                ST_IFACE: begin
                    if_q <= b;
                    state_q <= ST_FSEL;
                end
                ST_FSEL: begin
                    fs_q <= b;
                    ps_q <= 2'h0;
                    // Only power is walked; later fields are reported as present only.
                    state_q <= (b[`FS_PWR_MSB:`FS_PWR_LSB] != 2'h0) ? ST_PSEL : ST_DONE;
                end
                ST_PSEL: begin
                    pmask_q <= b[6:0];
                    if (b[6:0] != 7'h00) begin
                        state_q <= ST_PFIRST;
                    end else if (ps_q + 2'h1 < fs_q[`FS_PWR_MSB:`FS_PWR_LSB]) begin
                        ps_q <= ps_q + 2'h1;
                    end else begin
                        state_q <= ST_DONE;
                    end
                end
                ST_PFIRST, ST_PMORE: begin
                    if (state_q == ST_PFIRST) begin
                        pidx_q <= low_idx;
                    end
                    if (!par_done) begin
                        state_q <= ST_PMORE;
                    end else if ((state_q == ST_PFIRST ? mask_left
                                 : pmask_q) != 7'h00) begin
                        if (state_q == ST_PFIRST) begin
                            pmask_q <= mask_left;
                        end
                        state_q <= ST_PFIRST;
                    end else if (ps_q + 2'h1 < fs_q[`FS_PWR_MSB:`FS_PWR_LSB]) begin
                        ps_q <= ps_q + 2'h1;
                        state_q <= ST_PSEL;
                    end else begin
                        state_q <= ST_DONE;
                    end
                    if (state_q == ST_PFIRST && !par_done) begin
                        pmask_q <= mask_left;
                    end
                end
                ST_DONE: begin
                    state_q <= ST_DONE;
                end
                default: begin
                    state_q <= ST_INDEX;
                end
            endcase
        end
    end

    // Errors are sticky per entry; a new error beats the clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_q <= 4'h0;
        end else begin
            err_q <= (start ? 4'h0 : err_q) | err_set;
        end
    end

    // Default entry memory.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            have_def_q <= 1'b0;
            def_if_q <= `IF_DEFAULT_VAL;
            def_fs_q <= 8'h00;
        end else if (forget) begin
            have_def_q <= 1'b0;
        end else if (byte_v && state_q == ST_FSEL && dflt_q) begin
            have_def_q <= 1'b1;
            def_if_q <= if_q;
            def_fs_q <= b;
        end
    end

    // Parameter banks; the default bank survives until the next default entry.
    assign wr_idx = IW'(ps_q * NUM_PARAMS) +
                    IW'(state_q == ST_PFIRST ? low_idx : pidx_q);
    always_ff @(posedge clk_i) begin
        if (byte_v && par_done) begin
            cur_bank[wr_idx] <= par_d;
            if (dflt_q) begin
                def_bank[wr_idx] <= par_d;
            end
        end
    end

    // The banks keep no reset; these flags stop a new entry from showing older parameters.
    always_ff @(posedge clk_i) begin
        if (rst_i || start) begin
            cur_vld_q <= '0;
        end else if (byte_v && par_done) begin
            cur_vld_q[wr_idx] <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            def_vld_q <= '0;
        end else if (byte_v && state_q == ST_FSEL && dflt_q) begin
            def_vld_q <= '0;
        end else if (byte_v && par_done && dflt_q) begin
            def_vld_q[wr_idx] <= 1'b1;
        end
    end

    // Read mux.
    param_entry_t rd_par;
    logic rd_vld;
    logic [31:0] rd_data;
    always_comb begin
        rd_vld = 1'b0;
        rd_par = '0;
        if (32'(psel_q) < DEPTH) begin
            rd_vld = pwr_from_def ? def_vld_q[psel_q] : cur_vld_q[psel_q];
        end
        if (rd_vld) begin
            rd_par = pwr_from_def ? def_bank[psel_q] : cur_bank[psel_q];
        end
        rd_data = 32'h0000_0000;
        case (adr_i)
            `REG_STATUS: begin
                rd_data = {9'h000, entry_no_q, have_def_q, dflt_q, if_given_q,
                           2'h0, err_q, 1'b0, state_q};
            end
            `REG_IFACE: begin
                rd_data[7:0] = if_q;
                rd_data[8] = if_q[`IF_TYPE_MSB:0] >= `IF_TYPE_CUST_LO &&
                             if_q[`IF_TYPE_MSB:0] <= `IF_TYPE_CUST_HI;
                rd_data[10:9] = 2'(if_q[`IF_TYPE_MSB:0] - `IF_TYPE_CUST_LO);
                rd_data[11] = type_reserved(if_q[`IF_TYPE_MSB:0]);
                rd_data[12] = if_q[`IF_BATT_BIT];
                rd_data[13] = if_q[`IF_WP_BIT];
                rd_data[14] = if_q[`IF_READY_BIT];
                rd_data[15] = if_q[`IF_MWAIT_BIT];
            end
            `REG_FEAT: begin
                rd_data[7:0] = fs_q;
                rd_data[9:8] = eff_pwr;
                rd_data[10] = eff_timing;
                rd_data[11] = eff_io;
                rd_data[12] = eff_irq;
                rd_data[14:13] = eff_mem;
                rd_data[15] = eff_misc;
                rd_data[16] = pwr_from_def;
                // Worst-case wait stretch when no timing is known.
                rd_data[28:20] = eff_timing ? 9'h000 : 9'(`WAIT_MAX_CYC);
            end
            `REG_PSEL: begin
                rd_data[IW-1:0] = psel_q;
            end
            `REG_PDATA: begin
                rd_data[6:0] = mant_tenths(rd_par.mant);
                rd_data[10:7] = rd_par.mant;
                rd_data[13:11] = rd_par.expo;
                rd_data[14] = (psel_q % NUM_PARAMS) >= `NUM_VOLT_PARAMS;
                rd_data[21:15] = rd_par.digits;
                rd_data[24:22] = rd_par.count;
                rd_data[26:25] = rd_par.special;
                rd_data[27] = rd_par.valid & (eff_pwr != 2'h0);
            end
            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    // Bus slave: one wait state, ack for one cycle, unmapped reads return zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
            psel_q <= '0;
        end else begin
            ack_q <= wb_req;
            if (wb_req && !we_i) begin
                dat_q <= rd_data;
            end
            if (wr && adr_i == `REG_PSEL) begin
                psel_q <= IW'(dat_i[4:0]);
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_iface_default: assert property (
        (byte_v && !start && state_q == ST_INDEX && !b[7] && !have_def_q) |=>
        (if_q == `IF_DEFAULT_VAL && state_q == ST_FSEL))
        else $error("missing interface byte not replaced by 70h");
    a_type_reserved: assert property (
        (byte_v && state_q == ST_IFACE && b[3:0] inside {4'h2, 4'h3, [4'h8:4'hf]})
        |=> err_q[`ERR_TYPE])
        else $error("reserved interface type not flagged");
    a_power_walk: assert property (
        (byte_v && !start && state_q == ST_FSEL) |=>
        (state_q == ((fs_q[1:0] != 2'h0) ? ST_PSEL : ST_DONE)))
        else $error("power selector does not steer scan");
    a_sel_reserved: assert property (
        (byte_v && state_q == ST_PSEL && b[7]) |=> err_q[`ERR_SEL])
        else $error("reserved selection bit not flagged");
    a_more_chain: assert property (
        (byte_v && !start && state_q == ST_PFIRST && b[7]) |=> state_q == ST_PMORE)
        else $error("continuation bit did not open extension");
    a_xcode_rsv: assert property (
        (byte_v && state_q == ST_PMORE && b[6:0] > 7'h63 && b[6:0] < 7'h7d)
        |=> err_q[`ERR_XRSV])
        else $error("reserved extension code not flagged");
    a_special_pos: assert property (
        (byte_v && state_q == ST_PMORE && b[6:0] == 7'h7e && cur_q.count != 3'h0)
        |=> err_q[`ERR_XPOS])
        else $error("zero-required code not alone but accepted");
    a_bus_ack: assert property (
        (cyc_i && stb_i && !ack_q) |=> ack_q ##1 !ack_q)
        else $error("bus answer not a single cycle after request");

    c_default_entry: cover property (byte_v && state_q == ST_INDEX && b[6]);
    c_extension_run: cover property (state_q == ST_PMORE ##1 state_q == ST_PMORE);
    c_three_structs: cover property (state_q == ST_PSEL && ps_q == 2'h2);

endmodule

// *** verification/host_model.sv ***
// Bus master standing in for the host that reads the entry fields.
module host_model (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Status lines the host must recover from the pin replacement register.
    logic [3:0] needs_pins;

    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'hf;
        dat_o = 32'h0;
        needs_pins = 4'h0;
    end

    // Waits without limit; only the bench watchdog may cut a hang short.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        sel_o <= 4'hf;
        we_o <= w;
        adr_o <= a;
        dat_o <= d;
        @(posedge clk_i);
        while (ack_i !== 1'b1) @(posedge clk_i);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        if (!w && a == 8'h0c) needs_pins = q[15:12];
    endtask
endmodule

// *** verification/config_entry_field_decoder_bench.sv ***
`include "cfg_decoder_cfg.svh"

module config_entry_field_decoder_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, rst, cyc, stb, we, ack;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    int bad_count = 0;
    int n_compared = 0;

    host_model u_host_model (.clk_i(clk), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
        .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
    config_entry_field_decoder u_config_entry_field_decoder (.clk_i(clk), .rst_i(rst),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
        .dat_o(rdat), .ack_o(ack));

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host_model.bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a);
        u_host_model.bus(1'b0, a, 32'h0, q);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic entry(input logic [1:0] c, input logic [7:0] b[$]);
        wr(`REG_CTRL, {30'h0, c});
        foreach (b[i]) wr(`REG_BYTE, {24'h0, b[i]});
    endtask

    task automatic pd(input logic [4:0] i);
        wr(`REG_PSEL, {27'h0, i});
        rd(`REG_PDATA);
    endtask

    task automatic t_types;
        logic [3:0] t, f;
        logic cust, rsv;
        for (int i = 0; i < 16; i++) begin
            t = 4'(i);
            f = t ^ 4'h5;
            cust = t >= 4'h4 && t <= 4'h7;
            rsv = !cust && t > 4'h1;
            entry(2'b01, '{8'h81, {f, t}});
            rd(`REG_IFACE);
            chk(32'({q[15:11], q[8:0]}), 32'({f, rsv, cust, f, t}));
            chk(32'(u_host_model.needs_pins), 32'(f));
            if (cust) chk(32'(q[10:9]), 32'(2'(t - 4'h4)));
            rd(`REG_STATUS);
            chk(32'(q[8]), 32'(rsv));
        end
        entry(2'b01, '{8'h05});
        rd(`REG_IFACE);
        chk(32'({q[15:12], q[7:0]}), 32'h770);
        rd(8'h1c);
        chk(q, 32'h0);
        $display("interface types done");
    endtask

    task automatic t_power;
        logic [4:0] ix[6] = '{5'd1, 5'd2, 5'd3, 5'd4, 5'd6, 5'd12};
        logic [31:0] ex[6] = '{32'h8002a99, 32'h8002ec6, 32'h800600a, 32'h8006b1e,
                               32'h85956c6, 32'h8006d32};
        entry(2'b11, '{8'h01, 8'h02, 8'h5e, 8'h2d, 8'h6d, 8'h04, 8'h35, 8'hea, 8'h32,
                       8'h21, 8'h8e, 8'h7d, 8'h55});
        rd(`REG_FEAT);
        chk(32'({q[28:20], q[15:8]}), 32'h12c02);
        rd(`REG_STATUS);
        chk(32'(q[11:0]), 32'h040);
        pd(5'd0);
        chk(32'(q[27]), 32'h0);
        foreach (ix[i]) begin
            pd(ix[i]);
            chk(q, ex[i]);
        end
        pd(5'd7);
        chk(32'({q[27:22], q[13:0]}), 32'ha708c);
        entry(2'b11, '{8'h00, 8'h03, 8'h01, 8'h2d, 8'h01, 8'h35, 8'h01, 8'h55});
        rd(`REG_FEAT);
        chk(32'(q[9:8]), 32'h3);
        pd(5'd7);
        chk(q, 32'h8002b1e);
        pd(5'd14);
        chk(q, 32'h8002d32);
        pd(5'd12);
        chk(32'(q[27]), 32'h0);
        $display("power structures done");
    endtask

    task automatic t_inherit;
        entry(2'b11, '{8'h40, 8'h01, 8'h01, 8'h2d});
        entry(2'b01, '{8'h02, 8'h00});
        rd(`REG_FEAT);
        chk(32'({q[16], q[9:8]}), 32'h5);
        pd(5'd0);
        chk(q, 32'h8002a99);
        entry(2'b11, '{8'h03, 8'h00});
        rd(`REG_FEAT);
        chk(32'({q[16], q[9:8]}), 32'h0);
        $display("inheritance done");
    endtask

    task automatic t_fields;
        logic [7:0] fs[7] = '{8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h60, 8'h80};
        foreach (fs[i]) begin
            entry(2'b11, '{8'h00, fs[i]});
            rd(`REG_FEAT);
            chk(32'(q[15:10]), 32'(fs[i][7:2]));
        end
        entry(2'b11, '{8'h00, 8'h01, 8'h81, 8'h95, 8'h64});
        rd(`REG_STATUS);
        chk(32'(q[11:8]), 32'h6);
        entry(2'b11, '{8'h00, 8'h01, 8'h01, 8'h95, 8'h81, 8'h7e});
        rd(`REG_STATUS);
        chk(32'(q[11:8]), 32'h8);
        $display("fields and errors done");
    endtask

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // About six hundred cycles of traffic are expected; this leaves wide margin.
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        final_report();
    end

    initial begin
        rst = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_types();
        t_power();
        t_inherit();
        t_fields();
        final_report();
    end
endmodule
